// ### hdl/codec_clock_map.svh
/*
 Register indices, field positions, reset values and frequency figures of the
 codec clock source configuration block. Assumes inclusion by bare name.
*/
`ifndef CODEC_CLOCK_MAP_SVH
`define CODEC_CLOCK_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_CLOCK_SOURCE_CONFIG  6'h34
`define IDX_CTRL_CLOCK_CONFIG_0  6'h35
`define IDX_CTRL_CLOCK_CONFIG_1  6'h36
`define IDX_CTRL_CLOCK_CONFIG_2  6'h37
`define IDX_CLOCK_MODE_CONTROL   6'h3c
`define IDX_CLOCK_STATUS         6'h3d

`define RST_CLOCK_SOURCE_CONFIG  8'h40
`define RST_CTRL_CLOCK_CONFIG_0  8'h00
`define RST_CTRL_CLOCK_CONFIG_1  8'h00
`define RST_CTRL_CLOCK_CONFIG_2  8'h20
`define RST_CLOCK_MODE_CONTROL   8'h00

// Clock source config fields
`define POS_PLL_OFF              7
`define POS_PLL_FRACTIONAL       6
`define SRC_SEL_HI               3
`define SRC_SEL_LO               1
`define POS_RATIO_EDGE           0
`define MASK_CLOCK_SOURCE_CONFIG 8'hcf

// Controller config 0 / 2 fields
`define PDM_SEL_HI               7
`define PDM_SEL_LO               6
`define RATIO_HIGH_HI            5
`define MASK_CTRL_CLOCK_CONFIG_2 8'hf9
`define FREQ_SEL_HI              7
`define FREQ_SEL_LO              5
`define POS_RATE_FAMILY          0

// Mode control fields
`define POS_AUTO_MODE            0
`define POS_MISMATCH_CLEAR       1

// Ratio width and saturation
`define RATIO_W                  14
`define RATIO_MAX                14'h3fff

// Frequencies in Hz
`define HZ_PDM_48K_0             32'd3072000
`define HZ_PDM_48K_1             32'd1536000
`define HZ_PDM_48K_2             32'd768000
`define HZ_PDM_48K_3             32'd6144000
`define HZ_PDM_44K_0             32'd2822400
`define HZ_PDM_44K_1             32'd1411200
`define HZ_PDM_44K_2             32'd705600
`define HZ_PDM_44K_3             32'd5644800
`define HZ_CCLK_0                32'd12000000
`define HZ_CCLK_1                32'd12288000
`define HZ_CCLK_2                32'd13000000
`define HZ_CCLK_3                32'd16000000
`define HZ_CCLK_4                32'd19200000
`define HZ_CCLK_5                32'd19680000
`define HZ_CCLK_6                32'd24000000
`define HZ_CCLK_7                32'd24576000

`endif

// ### hdl/codec_clock_pkg.sv
/*
 Types shared by the codec clock source configuration block.
 Assumes the map header carries all numeric figures.
*/
package codec_clock_pkg;
	typedef enum logic [2:0] {
		src_pri_bclk,
		src_pri_sync,
		src_sec_bclk,
		src_sec_sync,
		src_fixed_cclk,
		src_oscillator,
		src_reserved_6,
		src_reserved_7
	} ref_source_e;

	typedef enum logic [1:0] {
		det_idle,
		det_counting
	} detect_state_e;
endpackage

// ### hdl/codec_clock_source_config.sv
/*
 Clock source configuration of an audio codec: reference clock select,
 PLL enable and fractional permit, PDM clock rate, common clock ratio
 with auto detection, reached over APB.
 Assumes all clock-like inputs are sampled synchronous to pclk, which
 runs well above them; a single clock domain with asynchronous reset.
*/
`timescale 1ns/1ns
`include "codec_clock_map.svh"
`default_nettype none

module codec_clock_source_config (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pri_bit_clock,
	input  wire logic        sec_bit_clock,
	input  wire logic        pri_frame_sync,
	input  wire logic        sec_frame_sync,
	input  wire logic        common_clock,
	input  wire logic        osc_clock,
	input  wire logic        dsp_pll_demand,
	output logic             ref_clock,
	output logic             pll_enable,
	output logic             pll_fractional_permit,
	output logic      [31:0] pdm_clock_hz,
	output logic      [31:0] common_clock_hz,
	output logic      [13:0] effective_ratio,
	output logic      [13:0] detected_ratio,
	output logic             ratio_mismatch
);

	logic [7:0]                         clock_source_config;
	logic [7:0]                         ctrl_cfg0;
	logic [7:0]                         ctrl_cfg1;
	logic [7:0]                         ctrl_cfg2;
	logic [7:0]                         mode_control;
	logic                               wr_en;
	logic [5:0]                         idx;
	codec_clock_pkg::ref_source_e       src_sel;
	logic [`RATIO_W-1:0]                prog_ratio;
	logic                               next_ref;
	logic                               ref_prev;
	logic                               fs_now;
	logic                               fs_prev;
	logic                               fs_rise;
	logic                               src_edge;
	logic [`RATIO_W-1:0]                edge_count;
	codec_clock_pkg::detect_state_e     det_state;

	function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
		hit = (a == b);
	endfunction

	function automatic logic [31:0] pdm_hz(input logic [1:0] code, input logic fam44);
		case (code)
			2'h0: pdm_hz = fam44 ? `HZ_PDM_44K_0 : `HZ_PDM_48K_0;
			2'h1: pdm_hz = fam44 ? `HZ_PDM_44K_1 : `HZ_PDM_48K_1;
			2'h2: pdm_hz = fam44 ? `HZ_PDM_44K_2 : `HZ_PDM_48K_2;
			default: pdm_hz = fam44 ? `HZ_PDM_44K_3 : `HZ_PDM_48K_3;
		endcase
	endfunction

	function automatic logic [31:0] cclk_hz(input logic [2:0] code);
		case (code)
			3'h0: cclk_hz = `HZ_CCLK_0;
			3'h1: cclk_hz = `HZ_CCLK_1;
			3'h2: cclk_hz = `HZ_CCLK_2;
			3'h3: cclk_hz = `HZ_CCLK_3;
			3'h4: cclk_hz = `HZ_CCLK_4;
			3'h5: cclk_hz = `HZ_CCLK_5;
			3'h6: cclk_hz = `HZ_CCLK_6;
			default: cclk_hz = `HZ_CCLK_7;
		endcase
	endfunction

	assign idx        = paddr[7:2];
	assign wr_en      = psel & penable & pready & pwrite;
	assign src_sel    = codec_clock_pkg::ref_source_e'(clock_source_config[`SRC_SEL_HI:`SRC_SEL_LO]);
	assign prog_ratio = {ctrl_cfg0[`RATIO_HIGH_HI:0], ctrl_cfg1};

	// APB: setup cycle prepares the answer, access phase completes in one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (psel && !penable) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			case (idx)
				`IDX_CLOCK_SOURCE_CONFIG: prdata[7:0] <= clock_source_config;
				`IDX_CTRL_CLOCK_CONFIG_0: prdata[7:0] <= ctrl_cfg0;
				`IDX_CTRL_CLOCK_CONFIG_1: prdata[7:0] <= ctrl_cfg1;
				`IDX_CTRL_CLOCK_CONFIG_2: prdata[7:0] <= ctrl_cfg2;
				`IDX_CLOCK_MODE_CONTROL:  prdata[7:0] <= mode_control;
				`IDX_CLOCK_STATUS: begin
					prdata[13:0]  <= detected_ratio;
					prdata[16]    <= ratio_mismatch;
					prdata[17]    <= pll_enable;
					prdata[18]    <= pll_fractional_permit;
				end
				default: pslverr <= 1'b1;
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Reserved bits masked on write so they always read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_source_config <= `RST_CLOCK_SOURCE_CONFIG;
		end else if (wr_en && hit(idx, `IDX_CLOCK_SOURCE_CONFIG)) begin
			clock_source_config <= pwdata[7:0] & `MASK_CLOCK_SOURCE_CONFIG;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_cfg0 <= `RST_CTRL_CLOCK_CONFIG_0;
			ctrl_cfg1 <= `RST_CTRL_CLOCK_CONFIG_1;
			ctrl_cfg2 <= `RST_CTRL_CLOCK_CONFIG_2;
		end else if (wr_en) begin
			if (hit(idx, `IDX_CTRL_CLOCK_CONFIG_0)) begin
				ctrl_cfg0 <= pwdata[7:0];
			end
			if (hit(idx, `IDX_CTRL_CLOCK_CONFIG_1)) begin
				ctrl_cfg1 <= pwdata[7:0];
			end
			if (hit(idx, `IDX_CTRL_CLOCK_CONFIG_2)) begin
				ctrl_cfg2 <= pwdata[7:0] & `MASK_CTRL_CLOCK_CONFIG_2;
			end
		end
	end

	// Mismatch clear bit is self-clearing, never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_control <= `RST_CLOCK_MODE_CONTROL;
		end else if (wr_en && hit(idx, `IDX_CLOCK_MODE_CONTROL)) begin
			mode_control <= {7'h0, pwdata[`POS_AUTO_MODE]};
		end
	end

	// PLL control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_enable            <= 1'b0;
			pll_fractional_permit <= 1'b1;
		end else begin
			if (clock_source_config[`POS_PLL_OFF]) begin
				pll_enable <= 1'b0;
			end else if (mode_control[`POS_AUTO_MODE]) begin
				pll_enable <= dsp_pll_demand;
			end else begin
				pll_enable <= 1'b1;
			end
			pll_fractional_permit <= clock_source_config[`POS_PLL_FRACTIONAL];
		end
	end

	// Reference clock mux; reserved codes give a quiet reference
	always_comb begin
		case (src_sel)
			codec_clock_pkg::src_pri_bclk:   next_ref = pri_bit_clock;
			codec_clock_pkg::src_pri_sync:   next_ref = common_clock;
			codec_clock_pkg::src_sec_bclk:   next_ref = sec_bit_clock;
			codec_clock_pkg::src_sec_sync:   next_ref = common_clock;
			codec_clock_pkg::src_fixed_cclk: next_ref = common_clock;
			codec_clock_pkg::src_oscillator: next_ref = osc_clock;
			default:                         next_ref = 1'b0;
		endcase
	end

	// Secondary frame sync only for the secondary-port sources
	assign fs_now = (src_sel == codec_clock_pkg::src_sec_bclk ||
			src_sel == codec_clock_pkg::src_sec_sync) ? sec_frame_sync : pri_frame_sync;
	assign fs_rise  = fs_now & ~fs_prev;
	assign src_edge = clock_source_config[`POS_RATIO_EDGE] ? (ref_prev & ~ref_clock)
			: (~ref_prev & ref_clock);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_clock <= 1'b0;
			ref_prev  <= 1'b0;
			fs_prev   <= 1'b0;
		end else begin
			ref_clock <= next_ref;
			ref_prev  <= ref_clock;
			fs_prev   <= fs_now;
		end
	end

	// Ratio detector: count edges from one frame sync rise to the next
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_state      <= codec_clock_pkg::det_idle;
			edge_count     <= '0;
			detected_ratio <= '0;
		end else begin
			case (det_state)
				codec_clock_pkg::det_idle: begin
					edge_count <= '0;
					if (fs_rise) begin
						det_state <= codec_clock_pkg::det_counting;
					end
				end
				codec_clock_pkg::det_counting: begin
					if (fs_rise) begin
						detected_ratio <= edge_count;
						edge_count     <= {{(`RATIO_W-1){1'b0}}, src_edge};
					end else if (src_edge && edge_count != `RATIO_MAX) begin
						edge_count <= edge_count + 14'h1;
					end
				end
				default: det_state <= codec_clock_pkg::det_idle;
			endcase
		end
	end

	// Mismatch: set wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ratio_mismatch <= 1'b0;
		end else if (det_state == codec_clock_pkg::det_counting && fs_rise &&
				prog_ratio != '0 && edge_count != prog_ratio) begin
			ratio_mismatch <= 1'b1;
		end else if (wr_en && hit(idx, `IDX_CLOCK_MODE_CONTROL) && pwdata[`POS_MISMATCH_CLEAR]) begin
			ratio_mismatch <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			effective_ratio <= '0;
			pdm_clock_hz    <= `HZ_PDM_48K_0;
			common_clock_hz <= `HZ_CCLK_1;
		end else begin
			effective_ratio <= (prog_ratio == '0) ? detected_ratio : prog_ratio;
			pdm_clock_hz    <= pdm_hz(ctrl_cfg0[`PDM_SEL_HI:`PDM_SEL_LO],
					ctrl_cfg2[`POS_RATE_FAMILY]);
			common_clock_hz <= cclk_hz(ctrl_cfg2[`FREQ_SEL_HI:`FREQ_SEL_LO]);
		end
	end

	sequence s_write_csc;
		psel && penable && pready && pwrite && idx == `IDX_CLOCK_SOURCE_CONFIG;
	endsequence

	property p_pll_off;
		@(posedge pclk) disable iff (!presetn)
		clock_source_config[`POS_PLL_OFF] |=> !pll_enable;
	endproperty
	a_pll_off: assert property (p_pll_off) else $error("PLL on while disabled");

	property p_pll_custom;
		@(posedge pclk) disable iff (!presetn)
		!clock_source_config[`POS_PLL_OFF] && !mode_control[`POS_AUTO_MODE] |=> pll_enable;
	endproperty
	a_pll_custom: assert property (p_pll_custom) else $error("PLL off in custom mode");

	property p_pll_auto;
		@(posedge pclk) disable iff (!presetn)
		!clock_source_config[`POS_PLL_OFF] && mode_control[`POS_AUTO_MODE] |=> pll_enable == $past(dsp_pll_demand);
	endproperty
	a_pll_auto: assert property (p_pll_auto) else $error("PLL ignores demand");

	property p_fractional;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> pll_fractional_permit == $past(clock_source_config[`POS_PLL_FRACTIONAL]);
	endproperty
	a_fractional: assert property (p_fractional) else $error("Fractional permit wrong");

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		s_write_csc |=> clock_source_config[5:4] == 2'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits stored");

	property p_osc_route;
		@(posedge pclk) disable iff (!presetn)
		src_sel == codec_clock_pkg::src_oscillator |=> ref_clock == $past(osc_clock);
	endproperty
	a_osc_route: assert property (p_osc_route) else $error("Oscillator not routed");

	property p_reserved_src;
		@(posedge pclk) disable iff (!presetn)
		src_sel == codec_clock_pkg::src_reserved_6 [*2] |-> !ref_clock;
	endproperty
	a_reserved_src: assert property (p_reserved_src) else $error("Reserved source active");

	property p_ratio_select;
		@(posedge pclk) disable iff (!presetn)
		prog_ratio != '0 && $stable(prog_ratio) |=> effective_ratio == $past(prog_ratio);
	endproperty
	a_ratio_select: assert property (p_ratio_select) else $error("Programmed ratio unused");

	property p_detect_latch;
		@(posedge pclk) disable iff (!presetn)
		det_state == codec_clock_pkg::det_counting && fs_rise |=> detected_ratio == $past(edge_count);
	endproperty
	a_detect_latch: assert property (p_detect_latch) else $error("Detected ratio not latched");

	property p_ref_pri;
		@(posedge pclk) disable iff (!presetn)
		src_sel == codec_clock_pkg::src_pri_bclk |=> ref_clock == $past(pri_bit_clock);
	endproperty
	a_ref_pri: assert property (p_ref_pri) else $error("Primary bit clock not routed");

	// Frame closed with a count that differs from a programmed ratio
	sequence s_ratio_miss;
		det_state == codec_clock_pkg::det_counting && fs_rise && prog_ratio != '0 && edge_count != prog_ratio;
	endsequence

	property p_mismatch_set;
		@(posedge pclk) disable iff (!presetn)
		s_ratio_miss |=> ratio_mismatch;
	endproperty
	a_mismatch_set: assert property (p_mismatch_set) else $error("Ratio mismatch not flagged");

	property p_auto_ratio;
		@(posedge pclk) disable iff (!presetn)
		prog_ratio == '0 |=> effective_ratio == $past(detected_ratio);
	endproperty
	a_auto_ratio: assert property (p_auto_ratio) else $error("Detected ratio unused");

endmodule

`default_nettype wire

// ### test/codec_clock_source_config_test.sv
/*
 Self-checking bench for the codec clock source configuration block.
 Assumes the map header is on the include path; APB answers may take any wait.
*/
`timescale 1ns/1ns
`include "codec_clock_map.svh"
`default_nettype none

`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; \
	$display("wrong value %s exp %h got %h", nm, ex, got); end end

module codec_clock_source_config_test;
	localparam logic [7:0] A_SRC  = {`IDX_CLOCK_SOURCE_CONFIG, 2'b00};
	localparam logic [7:0] A_C0   = {`IDX_CTRL_CLOCK_CONFIG_0, 2'b00};
	localparam logic [7:0] A_C1   = {`IDX_CTRL_CLOCK_CONFIG_1, 2'b00};
	localparam logic [7:0] A_C2   = {`IDX_CTRL_CLOCK_CONFIG_2, 2'b00};
	localparam logic [7:0] A_MODE = {`IDX_CLOCK_MODE_CONTROL, 2'b00};
	localparam logic [7:0] A_STAT = {`IDX_CLOCK_STATUS, 2'b00};
	localparam logic [31:0] pdm_tab [8] = '{`HZ_PDM_48K_0, `HZ_PDM_48K_1, `HZ_PDM_48K_2, `HZ_PDM_48K_3,
		`HZ_PDM_44K_0, `HZ_PDM_44K_1, `HZ_PDM_44K_2, `HZ_PDM_44K_3};
	localparam logic [31:0] cclk_tab [8] = '{`HZ_CCLK_0, `HZ_CCLK_1, `HZ_CCLK_2, `HZ_CCLK_3,
		`HZ_CCLK_4, `HZ_CCLK_5, `HZ_CCLK_6, `HZ_CCLK_7};

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  ins = 6'h00;
	logic        dsp_pll_demand = 1'b0;
	logic        ref_clock;
	logic        pll_enable;
	logic        pll_fractional_permit;
	logic [31:0] pdm_clock_hz;
	logic [31:0] common_clock_hz;
	logic [13:0] effective_ratio;
	logic [13:0] detected_ratio;
	logic        ratio_mismatch;
	int          fails = 0;
	int          n_tests = 0;
	logic [31:0] rd;
	logic        err;

	always #50 pclk = ~pclk;

	codec_clock_source_config codec_clock_source_config_inst (
		.pclk                  (pclk),
		.presetn               (presetn),
		.psel                  (psel),
		.penable               (penable),
		.pwrite                (pwrite),
		.paddr                 (paddr),
		.pwdata                (pwdata),
		.prdata                (prdata),
		.pready                (pready),
		.pslverr               (pslverr),
		.pri_bit_clock         (ins[0]),
		.sec_bit_clock         (ins[1]),
		.pri_frame_sync        (ins[2]),
		.sec_frame_sync        (ins[3]),
		.common_clock          (ins[4]),
		.osc_clock             (ins[5]),
		.dsp_pll_demand        (dsp_pll_demand),
		.ref_clock             (ref_clock),
		.pll_enable            (pll_enable),
		.pll_fractional_permit (pll_fractional_permit),
		.pdm_clock_hz          (pdm_clock_hz),
		.common_clock_hz       (common_clock_hz),
		.effective_ratio       (effective_ratio),
		.detected_ratio        (detected_ratio),
		.ratio_mismatch        (ratio_mismatch)
	);

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a hang; values read here are those from before the edge
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
		repeat (3) @(posedge pclk);
	endtask

	// Bit clock rises every 4 cycles, frame sync every 32: eight edges a frame
	task automatic run_frames(input int n);
		for (int c = 0; c < n; c++) begin
			@(posedge pclk);
			ins <= {3'b000, c[4], 1'b0, c[1]};
		end
		repeat (3) @(posedge pclk);
	endtask

	task automatic t_reset;
		apb(1'b0, A_SRC, 32'h0);
		`CHK("src cfg", 32'h40, rd)
		apb(1'b0, A_C0, 32'h0);
		`CHK("cfg0", 32'h0, rd)
		apb(1'b0, A_C1, 32'h0);
		`CHK("cfg1", 32'h0, rd)
		apb(1'b0, A_C2, 32'h0);
		`CHK("cfg2", 32'h20, rd)
		`CHK("pll", 1'b1, pll_enable)
		`CHK("frac", 1'b1, pll_fractional_permit)
		`CHK("pdm", `HZ_PDM_48K_0, pdm_clock_hz)
		`CHK("cclk", `HZ_CCLK_1, common_clock_hz)
		apb(1'b0, 8'h00, 32'h0);
		`CHK("unmapped err", 1'b1, err)
	endtask

	task automatic t_pll;
		wr8(A_SRC, 8'hcf);
		apb(1'b0, A_SRC, 32'h0);
		`CHK("reserved", 32'hcf, rd)
		`CHK("pll off", 1'b0, pll_enable)
		wr8(A_SRC, 8'h00);
		`CHK("pll on", 1'b1, pll_enable)
		`CHK("frac off", 1'b0, pll_fractional_permit)
		wr8(A_MODE, 8'h01);
		`CHK("auto idle", 1'b0, pll_enable)
		dsp_pll_demand <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK("auto demand", 1'b1, pll_enable)
		wr8(A_SRC, 8'h80);
		`CHK("auto off", 1'b0, pll_enable)
		wr8(A_MODE, 8'h00);
	endtask

	task automatic t_source;
		int idx;
		// Fixed common clock code is legal only with the port in controller role
		wr8(A_C2, 8'h30);
		for (int c = 0; c < 8; c++) begin
			wr8(A_SRC, 8'h40 | 8'(c << 1));
			idx = (c == 0) ? 0 : (c == 2) ? 1 : (c == 5) ? 5 : 4;
			for (int v = 0; v < 2; v++) begin
				ins <= v[0] ? 6'(1 << idx) : ~6'(1 << idx);
				repeat (3) @(posedge pclk);
				`CHK("ref clock", (c < 6) ? v[0] : 1'b0, ref_clock)
			end
		end
		ins <= 6'h00;
		wr8(A_C2, 8'h20);
	endtask

	task automatic t_rates;
		for (int f = 0; f < 2; f++)
			for (int c = 0; c < 4; c++) begin
				wr8(A_C2, 8'h20 | 8'(f));
				wr8(A_C0, 8'(c << 6));
				`CHK("pdm hz", pdm_tab[f * 4 + c], pdm_clock_hz)
			end
		for (int k = 0; k < 8; k++) begin
			wr8(A_C2, 8'(k << 5));
			`CHK("cclk hz", cclk_tab[k], common_clock_hz)
		end
		wr8(A_C2, 8'h20);
	endtask

	task automatic t_ratio;
		wr8(A_C0, 8'h3f);
		wr8(A_C1, 8'hff);
		`CHK("ratio max", 14'h3fff, effective_ratio)
		wr8(A_C0, 8'h01);
		wr8(A_C1, 8'h02);
		`CHK("ratio split", 14'h0102, effective_ratio)
		wr8(A_C0, 8'h00);
		wr8(A_C1, 8'h00);
		wr8(A_SRC, 8'h40);
		run_frames(200);
		`CHK("det rise", 14'd8, detected_ratio)
		`CHK("auto ratio", 14'd8, effective_ratio)
		`CHK("no mismatch", 1'b0, ratio_mismatch)
		wr8(A_SRC, 8'h41);
		run_frames(200);
		`CHK("det fall", 14'd8, detected_ratio)
		wr8(A_C1, 8'h09);
		run_frames(100);
		`CHK("prog ratio", 14'd9, effective_ratio)
		`CHK("mismatch", 1'b1, ratio_mismatch)
		apb(1'b0, A_STAT, 32'h0);
		`CHK("status", 32'h00070008, rd)
		wr8(A_MODE, 8'h02);
		`CHK("cleared", 1'b0, ratio_mismatch)
		apb(1'b0, A_MODE, 32'h0);
		`CHK("mode", 32'h0, rd)
	endtask

	task automatic report_and_stop;
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_pll;
		t_source;
		t_rates;
		t_ratio;
		report_and_stop;
	end

	// Whole run takes about 900 cycles; over twenty times that means a hang
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		report_and_stop;
	end
endmodule

`default_nettype wire
